// *** tcs_pkg.sv ***
// Constants and types for the cascaded dual 8-bit timer
// Functional notes
// - Either channel selecting the cascade clock code 100 links the two timers into a pair.
// - Channel 0 on code 100 makes one 16-bit counter, channel 0 high byte, channel 1 low byte.
// - In 16-bit mode the channel 0 match flag sets only on a full 16-bit compare match.
// - In 16-bit mode the channel 1 match flag sets on a low-byte match whatever the high byte.
// - In 16-bit mode a channel 0 clear-on-match setting clears both counters on a 16-bit match.
// - That joint clear on 16-bit compare match A also happens when clearing by the reset pin is chosen.
// - In 16-bit mode channel 1's clear setting is ignored and the low byte never clears alone.
// - In 16-bit mode channel 0's output pin follows its output select on 16-bit matches.
// - In 16-bit mode channel 1's output pin follows its output select on low-byte matches.
// - Channel 1 on code 100, with channel 0 on another code, counts one step per compare match A of channel 0.
// - In match count mode each channel keeps its own flags, interrupts, pin and clearing.
package tcs_pkg;
  // ==========================================
  // Register offsets
  localparam logic [7:0] OFF_CTRL   = 8'h00;
  localparam logic [7:0] OFF_CSR    = 8'h04;
  localparam logic [7:0] OFF_CMPA   = 8'h08;
  localparam logic [7:0] OFF_CMPB   = 8'h0c;
  localparam logic [7:0] OFF_CNT    = 8'h10;
  localparam logic [7:0] CH_STRIDE  = 8'h20;
  localparam logic [7:0] OFF_STAT   = 8'h40;
  localparam logic [7:0] OFF_MASK   = 8'h44;
  localparam logic [7:0] OFF_MODE   = 8'h48;
  // ==========================================
  // Field positions
  localparam int CKS_LSB  = 0;
  localparam int CLR_LSB  = 3;
  localparam int PIN_BIT  = 4;
  localparam int STAT_W   = 4;
  // ==========================================
  // Reset values
  localparam logic [7:0] RST_CTRL = 8'h00;
  localparam logic [7:0] RST_CMP  = 8'hff;
  localparam logic [7:0] RST_CNT  = 8'h00;
  localparam logic [3:0] RST_OS   = 4'h0;
  localparam logic [3:0] RST_STAT = 4'h0;
  // ==========================================
  // Prescaler taps
  localparam logic [5:0] PRE_DIV8_MASK  = 6'h07;
  localparam logic [5:0] PRE_DIV64_MASK = 6'h3f;
  // ==========================================
  // Bus responses
  localparam logic [1:0] RESP_OKAY   = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;
  // ==========================================
  // Codes
  typedef enum logic [2:0] {
    CKS_STOP  = 3'b000,
    CKS_DIV1  = 3'b001,
    CKS_DIV8  = 3'b010,
    CKS_DIV64 = 3'b011,
    CKS_CASC  = 3'b100
  } tcs_cks_type;
  typedef enum logic [1:0] {
    CLR_NONE = 2'b00,
    CLR_MA   = 2'b01,
    CLR_MB   = 2'b10,
    CLR_PIN  = 2'b11
  } tcs_clr_type;
  typedef enum logic [1:0] {
    OS_KEEP = 2'b00,
    OS_LOW  = 2'b01,
    OS_HIGH = 2'b10,
    OS_TOG  = 2'b11
  } tcs_os_type;
endpackage

// *** tcs_pin.sv ***
// Timer output pin control for one channel
`timescale 1ns/1ns
module tcs_pin import tcs_pkg::*; (
  // Clock and reset
  input  wire logic       clk,
  input  wire logic       rst_n,
  // Match events and output select
  input  wire logic       ev_a,
  input  wire logic       ev_b,
  input  wire logic [3:0] output_select_field,
  // Pin level
  output logic            pin
);
  logic pin_r;
  logic pin_b;
  logic pin_nxt;

  function automatic logic apply_os(input logic [1:0] os, input logic cur);
    case (os)
      OS_LOW:  apply_os = 1'b0;
      OS_HIGH: apply_os = 1'b1;
      OS_TOG:  apply_os = ~cur;
      default: apply_os = cur;
    endcase
  endfunction

  // ==========================================
  // Match B first, match A last
  assign pin_b   = ev_b ? apply_os(output_select_field[3:2], pin_r) : pin_r;
  assign pin_nxt = ev_a ? apply_os(output_select_field[1:0], pin_b) : pin_b;
  assign pin     = pin_r;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pin_r <= 1'b0;
    end else begin
      pin_r <= pin_nxt;
    end
  end

  // ==========================================
  // Checks
  chk_pin_set_high: assert property (@(posedge clk) disable iff (!rst_n)
    ev_a && !ev_b && output_select_field[1:0] == OS_HIGH |=> pin_r)
    else $error("pin not driven high on match A");
  chk_pin_toggle: assert property (@(posedge clk) disable iff (!rst_n)
    ev_a && !ev_b && output_select_field[1:0] == OS_TOG |=> pin_r != $past(pin_r))
    else $error("pin did not toggle on match A");
endmodule

// *** tcs_axil.sv ***
// AXI4-Lite slave front end for the timer registers
`timescale 1ns/1ns
module tcs_axil import tcs_pkg::*; #(
  parameter int AW = 8
) (
  // Clock and reset
  input  wire logic          clk,
  input  wire logic          rst_n,
  // Write address and data
  input  wire logic [AW-1:0] awaddr,
  input  wire logic          awvalid,
  output logic               awready,
  input  wire logic [31:0]   wdata,
  input  wire logic [3:0]    wstrb,
  input  wire logic          wvalid,
  output logic               wready,
  // Write response
  output logic [1:0]         bresp,
  output logic               bvalid,
  input  wire logic          bready,
  // Read address and data
  input  wire logic [AW-1:0] araddr,
  input  wire logic          arvalid,
  output logic               arready,
  output logic [31:0]        rdata,
  output logic [1:0]         rresp,
  output logic               rvalid,
  input  wire logic          rready,
  // Register side
  output logic               wr_en,
  output logic [AW-1:0]      wr_addr,
  output logic [31:0]        wr_data,
  output logic [3:0]         wr_strb,
  input  wire logic          wr_ok,
  output logic [AW-1:0]      rd_addr,
  input  wire logic [31:0]   rd_data,
  input  wire logic          rd_ok
);
  logic          aw_full_r;
  logic          w_full_r;
  logic [AW-1:0] addr_r;
  logic [31:0]   data_r;
  logic [3:0]    strb_r;
  logic          bvalid_r;
  logic [1:0]    bresp_r;
  logic          rvalid_r;
  logic [31:0]   rdata_r;
  logic [1:0]    rresp_r;
  logic          aw_fire;
  logic          w_fire;
  logic          ar_fire;

  // ==========================================
  // Handshakes
  assign awready = ~aw_full_r;
  assign wready  = ~w_full_r;
  assign arready = ~rvalid_r;
  assign aw_fire = awvalid & ~aw_full_r;
  assign w_fire  = wvalid & ~w_full_r;
  assign ar_fire = arvalid & ~rvalid_r;
  assign wr_en   = aw_full_r & w_full_r & ~bvalid_r;
  assign wr_addr = addr_r;
  assign wr_data = data_r;
  assign wr_strb = strb_r;
  assign rd_addr = araddr;
  assign bvalid  = bvalid_r;
  assign bresp   = bresp_r;
  assign rvalid  = rvalid_r;
  assign rdata   = rdata_r;
  assign rresp   = rresp_r;

  // ==========================================
  // Write path
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      aw_full_r <= 1'b0;
      addr_r    <= '0;
    end else if (aw_fire) begin
      aw_full_r <= 1'b1;
      addr_r    <= awaddr;
    end else if (wr_en) begin
      aw_full_r <= 1'b0;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      w_full_r <= 1'b0;
      data_r   <= 32'h0000_0000;
      strb_r   <= 4'h0;
    end else if (w_fire) begin
      w_full_r <= 1'b1;
      data_r   <= wdata;
      strb_r   <= wstrb;
    end else if (wr_en) begin
      w_full_r <= 1'b0;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      bvalid_r <= 1'b0;
      bresp_r  <= RESP_OKAY;
    end else if (wr_en) begin
      bvalid_r <= 1'b1;
      bresp_r  <= wr_ok ? RESP_OKAY : RESP_SLVERR;
    end else if (bready) begin
      bvalid_r <= 1'b0;
    end
  end

  // ==========================================
  // Read path
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rvalid_r <= 1'b0;
      rdata_r  <= 32'h0000_0000;
      rresp_r  <= RESP_OKAY;
    end else if (ar_fire) begin
      rvalid_r <= 1'b1;
      rdata_r  <= rd_data;
      rresp_r  <= rd_ok ? RESP_OKAY : RESP_SLVERR;
    end else if (rready) begin
      rvalid_r <= 1'b0;
    end
  end
endmodule

// *** tcs_top.sv ***
// Cascaded dual 8-bit timer with AXI4-Lite registers
//
// Decided for this implementation: register access over AXI4-Lite and the placing of the registers.
`timescale 1ns/1ns
module tcs_top import tcs_pkg::*; (
  // Clock and reset
  input  wire logic        CORE_CLK,
  input  wire logic        RST_N,
  // AXI4-Lite write address
  input  wire logic [7:0]  S_AXI_AWADDR,
  input  wire logic        S_AXI_AWVALID,
  output logic             S_AXI_AWREADY,
  // AXI4-Lite write data
  input  wire logic [31:0] S_AXI_WDATA,
  input  wire logic [3:0]  S_AXI_WSTRB,
  input  wire logic        S_AXI_WVALID,
  output logic             S_AXI_WREADY,
  // AXI4-Lite write response
  output logic [1:0]       S_AXI_BRESP,
  output logic             S_AXI_BVALID,
  input  wire logic        S_AXI_BREADY,
  // AXI4-Lite read address
  input  wire logic [7:0]  S_AXI_ARADDR,
  input  wire logic        S_AXI_ARVALID,
  output logic             S_AXI_ARREADY,
  // AXI4-Lite read data
  output logic [31:0]      S_AXI_RDATA,
  output logic [1:0]       S_AXI_RRESP,
  output logic             S_AXI_RVALID,
  input  wire logic        S_AXI_RREADY,
  // Timer pins
  input  wire logic [1:0]  EXT_COUNTER_RESET_INPUT,
  output logic             CH0_TIMER_OUTPUT_PIN,
  output logic             CH1_TIMER_OUTPUT_PIN,
  // Interrupt
  output logic             IRQ
);
  logic [7:0]  ctrl_r [2];
  logic [3:0]  os_r   [2];
  logic [7:0]  cmpa_r [2];
  logic [7:0]  cmpb_r [2];
  logic [7:0]  cnt_r  [2];
  logic [7:0]  cnt_nxt [2];
  logic [STAT_W-1:0] stat_r;
  logic [STAT_W-1:0] stat_nxt;
  logic [STAT_W-1:0] mask_r;
  logic [5:0]  pre_r;
  logic [1:0]  eqa_r;
  logic [1:0]  eqb_r;
  logic [1:0]  ext_prev_r;

  logic        wr_en;
  logic [7:0]  wr_addr;
  logic [31:0] wr_data;
  logic [3:0]  wr_strb;
  logic        wr_ok;
  logic [7:0]  rd_addr;
  logic [31:0] rd_data;
  logic        rd_ok;
  logic        wr_b0;

  logic [1:0]  wr_ctrl;
  logic [1:0]  wr_csr;
  logic [1:0]  wr_cmpa;
  logic [1:0]  wr_cmpb;
  logic [1:0]  wr_cnt;
  logic        wr_stat;
  logic        wr_mask;
  logic        wr_hit_ch;

  logic        mode16;
  logic        mcount;
  logic        eq16a;
  logic        eq16b;
  logic [1:0]  eqa;
  logic [1:0]  eqb;
  logic [1:0]  eva;
  logic [1:0]  evb;
  logic [1:0]  ext_edge;
  logic [1:0]  tick;
  logic [1:0]  clr_own;
  logic [1:0]  clr;
  logic [1:0]  inc;
  logic [1:0]  pin_lvl;
  tcs_clr_type clr_sel [2];
  tcs_cks_type cks     [2];

  // ==========================================
  // Bus slave
  tcs_axil #(.AW(8)) u_axil (
    .clk     (CORE_CLK),
    .rst_n   (RST_N),
    .awaddr  (S_AXI_AWADDR),
    .awvalid (S_AXI_AWVALID),
    .awready (S_AXI_AWREADY),
    .wdata   (S_AXI_WDATA),
    .wstrb   (S_AXI_WSTRB),
    .wvalid  (S_AXI_WVALID),
    .wready  (S_AXI_WREADY),
    .bresp   (S_AXI_BRESP),
    .bvalid  (S_AXI_BVALID),
    .bready  (S_AXI_BREADY),
    .araddr  (S_AXI_ARADDR),
    .arvalid (S_AXI_ARVALID),
    .arready (S_AXI_ARREADY),
    .rdata   (S_AXI_RDATA),
    .rresp   (S_AXI_RRESP),
    .rvalid  (S_AXI_RVALID),
    .rready  (S_AXI_RREADY),
    .wr_en   (wr_en),
    .wr_addr (wr_addr),
    .wr_data (wr_data),
    .wr_strb (wr_strb),
    .wr_ok   (wr_ok),
    .rd_addr (rd_addr),
    .rd_data (rd_data),
    .rd_ok   (rd_ok)
  );

  // ==========================================
  // Write decode
  assign wr_b0     = wr_en & wr_strb[0];
  assign wr_stat   = wr_b0 & (wr_addr == OFF_STAT);
  assign wr_mask   = wr_b0 & (wr_addr == OFF_MASK);
  assign wr_hit_ch = (wr_addr[7:6] == 2'b00) & (wr_addr[1:0] == 2'b00) & (wr_addr[4:0] <= OFF_CNT[4:0]);
  assign wr_ok     = wr_hit_ch | (wr_addr == OFF_STAT) | (wr_addr == OFF_MASK) | (wr_addr == OFF_MODE);

  // ==========================================
  // Read decode
  always_comb begin
    rd_data = 32'h0000_0000;
    rd_ok   = 1'b1;
    case (rd_addr)
      OFF_CTRL:              rd_data[4:0] = ctrl_r[0][4:0];
      OFF_CSR:               rd_data[4:0] = {pin_lvl[0], os_r[0]};
      OFF_CMPA:              rd_data[7:0] = cmpa_r[0];
      OFF_CMPB:              rd_data[7:0] = cmpb_r[0];
      OFF_CNT:               rd_data[7:0] = cnt_r[0];
      OFF_CTRL + CH_STRIDE:  rd_data[4:0] = ctrl_r[1][4:0];
      OFF_CSR + CH_STRIDE:   rd_data[4:0] = {pin_lvl[1], os_r[1]};
      OFF_CMPA + CH_STRIDE:  rd_data[7:0] = cmpa_r[1];
      OFF_CMPB + CH_STRIDE:  rd_data[7:0] = cmpb_r[1];
      OFF_CNT + CH_STRIDE:   rd_data[7:0] = cnt_r[1];
      OFF_STAT:              rd_data[STAT_W-1:0] = stat_r;
      OFF_MASK:              rd_data[STAT_W-1:0] = mask_r;
      OFF_MODE:              rd_data[1:0] = {mcount, mode16};
      default:               rd_ok = 1'b0;
    endcase
  end

  // ==========================================
  // Mode selection
  // cascade on either code
  assign cks[0]  = tcs_cks_type'(ctrl_r[0][CKS_LSB +: 3]);
  assign cks[1]  = tcs_cks_type'(ctrl_r[1][CKS_LSB +: 3]);
  // channel 0 code gives 16-bit mode
  assign mode16  = (cks[0] == CKS_CASC);
  assign mcount  = ~mode16 & (cks[1] == CKS_CASC);
  assign clr_sel[0] = tcs_clr_type'(ctrl_r[0][CLR_LSB +: 2]);
  assign clr_sel[1] = tcs_clr_type'(ctrl_r[1][CLR_LSB +: 2]);

  // ==========================================
  // Compare logic
  // joined compare value
  assign eq16a  = ({cnt_r[0], cnt_r[1]} == {cmpa_r[0], cmpa_r[1]});
  assign eq16b  = ({cnt_r[0], cnt_r[1]} == {cmpb_r[0], cmpb_r[1]});
  assign eqa[0] = mode16 ? eq16a : (cnt_r[0] == cmpa_r[0]);
  assign eqb[0] = mode16 ? eq16b : (cnt_r[0] == cmpb_r[0]);
  // channel 1 match is low byte
  assign eqa[1] = (cnt_r[1] == cmpa_r[1]);
  assign eqb[1] = (cnt_r[1] == cmpb_r[1]);
  assign eva    = eqa & ~eqa_r;
  assign evb    = eqb & ~eqb_r;
  assign ext_edge = EXT_COUNTER_RESET_INPUT & ~ext_prev_r;

  // ==========================================
  // Clearing
  // joint clear on 16-bit match
  // match clear kept in pin mode
  assign clr[0] = clr_own[0] | (mode16 & (clr_sel[0] == CLR_PIN) & eva[0]);
  // low byte follows channel 0 only
  assign clr[1] = mode16 ? clr[0] : clr_own[1];

  // ==========================================
  // Count enables
  // count channel 0 match A
  assign inc[1] = mcount ? eva[0] : tick[1];
  assign inc[0] = mode16 ? (inc[1] & (cnt_r[1] == 8'hff)) : tick[0];

  // ==========================================
  // Per channel logic
  genvar i;
  generate
    for (i = 0; i < 2; i++) begin : g_ch
      localparam logic [7:0] BASE = (i == 0) ? 8'h00 : CH_STRIDE;
      assign wr_ctrl[i] = wr_b0 & (wr_addr == BASE + OFF_CTRL);
      assign wr_csr[i]  = wr_b0 & (wr_addr == BASE + OFF_CSR);
      assign wr_cmpa[i] = wr_b0 & (wr_addr == BASE + OFF_CMPA);
      assign wr_cmpb[i] = wr_b0 & (wr_addr == BASE + OFF_CMPB);
      assign wr_cnt[i]  = wr_b0 & (wr_addr == BASE + OFF_CNT);
      assign tick[i]    = (cks[i] == CKS_DIV1)
                        | ((cks[i] == CKS_DIV8) & ((pre_r & PRE_DIV8_MASK) == PRE_DIV8_MASK))
                        | ((cks[i] == CKS_DIV64) & (pre_r == PRE_DIV64_MASK));
      assign clr_own[i] = ((clr_sel[i] == CLR_MA) & eva[i])
                        | ((clr_sel[i] == CLR_MB) & evb[i])
                        | ((clr_sel[i] == CLR_PIN) & ext_edge[i]);
      assign cnt_nxt[i] = clr[i] ? RST_CNT : wr_cnt[i] ? wr_data[7:0] :
                          inc[i] ? 8'(cnt_r[i] + 8'h01) : cnt_r[i];

      always_ff @(posedge CORE_CLK or negedge RST_N) begin
        if (!RST_N) begin
          ctrl_r[i] <= RST_CTRL;
          os_r[i]   <= RST_OS;
          cmpa_r[i] <= RST_CMP;
          cmpb_r[i] <= RST_CMP;
          cnt_r[i]  <= RST_CNT;
        end else begin
          ctrl_r[i] <= wr_ctrl[i] ? {3'h0, wr_data[4:0]} : ctrl_r[i];
          os_r[i]   <= wr_csr[i] ? wr_data[3:0] : os_r[i];
          cmpa_r[i] <= wr_cmpa[i] ? wr_data[7:0] : cmpa_r[i];
          cmpb_r[i] <= wr_cmpb[i] ? wr_data[7:0] : cmpb_r[i];
          cnt_r[i]  <= cnt_nxt[i];
        end
      end

      // channel 1 pin on low byte
      tcs_pin u_pin (
        .clk                 (CORE_CLK),
        .rst_n               (RST_N),
        .ev_a                (eva[i]),
        .ev_b                (evb[i]),
        .output_select_field (os_r[i]),
        .pin                 (pin_lvl[i])
      );
    end
  endgenerate

  assign CH0_TIMER_OUTPUT_PIN = pin_lvl[0];
  assign CH1_TIMER_OUTPUT_PIN = pin_lvl[1];

  // ==========================================
  // Status, mask and interrupt
  // flags per channel
  assign stat_nxt = (stat_r & ~(wr_stat ? wr_data[STAT_W-1:0] : {STAT_W{1'b0}})) | {evb[1], eva[1], evb[0], eva[0]};
  assign IRQ      = |(stat_r & mask_r);

  always_ff @(posedge CORE_CLK or negedge RST_N) begin
    if (!RST_N) begin
      stat_r <= RST_STAT;
      mask_r <= RST_STAT;
    end else begin
      stat_r <= stat_nxt;
      mask_r <= wr_mask ? wr_data[STAT_W-1:0] : mask_r;
    end
  end

  always_ff @(posedge CORE_CLK or negedge RST_N) begin
    if (!RST_N) begin
      pre_r      <= 6'h00;
      eqa_r      <= 2'b00;
      eqb_r      <= 2'b00;
      ext_prev_r <= 2'b00;
    end else begin
      pre_r      <= 6'(pre_r + 6'h01);
      eqa_r      <= eqa;
      eqb_r      <= eqb;
      ext_prev_r <= EXT_COUNTER_RESET_INPUT;
    end
  end

  // ==========================================
  // Checks
  default clocking cb @(posedge CORE_CLK); endclocking
  default disable iff (!RST_N);

  chk_high_holds: assert property (
    mode16 && cnt_r[1] != 8'hff && !clr[0] && !wr_cnt[0] |=> $stable(cnt_r[0]))
    else $error("high byte moved without low byte rollover");
  chk_carry_up: assert property (
    mode16 && inc[1] && cnt_r[1] == 8'hff && !clr[0] && !wr_cnt[0] |=> cnt_r[0] == 8'($past(cnt_r[0]) + 8'h01))
    else $error("high byte missed carry");
  chk_flag16_only: assert property (
    mode16 && cnt_r[0] != cmpa_r[0] && !stat_r[0] |=> !stat_r[0])
    else $error("channel 0 flag set without 16-bit match");
  chk_low_flag: assert property (
    mode16 && cnt_r[1] == cmpa_r[1] && !eqa_r[1] |=> stat_r[2])
    else $error("channel 1 flag missed low byte match");
  chk_joint_clear: assert property (
    mode16 && clr_sel[0] == CLR_MA && {cnt_r[0], cnt_r[1]} == {cmpa_r[0], cmpa_r[1]} && !eqa_r[0]
    |=> cnt_r[0] == 8'h00 && cnt_r[1] == 8'h00)
    else $error("16-bit match did not clear both counters");
  chk_pin_mode_clear: assert property (
    mode16 && clr_sel[0] == CLR_PIN && eva[0] |=> cnt_r[0] == 8'h00 && cnt_r[1] == 8'h00)
    else $error("pin clear mode lost the match clear");
  chk_low_no_clear: assert property (
    mode16 && !clr[0] && !wr_cnt[1] && cnt_r[1] != 8'hff |=> cnt_r[1] >= $past(cnt_r[1]))
    else $error("low byte cleared on its own");
  chk_match_count: assert property (
    mcount && eva[0] && !clr[1] && !wr_cnt[1] |=> cnt_r[1] == 8'($past(cnt_r[1]) + 8'h01))
    else $error("channel 1 missed channel 0 match A");
  chk_indep_clear: assert property (
    mcount && clr_sel[1] == CLR_MA && eva[1] |=> cnt_r[1] == 8'h00 && stat_r[2])
    else $error("channel 1 own clear failed");
  chk_cascade_code: assert property (
    (cks[0] == CKS_CASC || cks[1] == CKS_CASC) |-> (mode16 || mcount))
    else $error("cascade code did not link channels");
endmodule

// *** tb_tcs_top.sv ***
// Self-checking bench for the cascaded dual timer
`timescale 1ns/1ns
module tb_tcs_top import tcs_pkg::*;;
  // ==========================================
  // Bench signals
  logic        clk;
  logic        rst_n;
  logic        awv;
  logic        wv;
  logic        bre;
  logic        arv;
  logic        rre;
  logic [7:0]  awa;
  logic [7:0]  ara;
  logic [31:0] wd;
  logic [31:0] d;
  logic [1:0]  pin_rst;
  wire logic   awr;
  wire logic   wr;
  wire logic   bv;
  wire logic   arr;
  wire logic   rv;
  wire logic   p0;
  wire logic   p1;
  wire logic   irq;
  wire logic [1:0]  br;
  wire logic [1:0]  rr;
  wire logic [31:0] rdat;
  int          err_total;
  int          samples_checked;

  // ==========================================
  // Design under test
  tcs_top dut (
    .CORE_CLK(clk), .RST_N(rst_n),
    .S_AXI_AWADDR(awa), .S_AXI_AWVALID(awv), .S_AXI_AWREADY(awr),
    .S_AXI_WDATA(wd), .S_AXI_WSTRB(4'hf), .S_AXI_WVALID(wv), .S_AXI_WREADY(wr),
    .S_AXI_BRESP(br), .S_AXI_BVALID(bv), .S_AXI_BREADY(bre),
    .S_AXI_ARADDR(ara), .S_AXI_ARVALID(arv), .S_AXI_ARREADY(arr),
    .S_AXI_RDATA(rdat), .S_AXI_RRESP(rr), .S_AXI_RVALID(rv), .S_AXI_RREADY(rre),
    .EXT_COUNTER_RESET_INPUT(pin_rst), .CH0_TIMER_OUTPUT_PIN(p0), .CH1_TIMER_OUTPUT_PIN(p1),
    .IRQ(irq)
  );

  // ==========================================
  // Clock
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  // ==========================================
  // Compare and report
  task automatic chk_val(input logic [31:0] g, input logic [31:0] e);
    samples_checked++;
    if (g !== e) begin
      err_total++;
      $display("MISMATCH t=%0t value %h expected %h", $time, g, e);
    end
  endtask

  task automatic chk_bit(input logic g, input logic e);
    samples_checked++;
    if (g !== e) begin
      err_total++;
      $display("MISMATCH t=%0t bit %b expected %b", $time, g, e);
    end
  endtask

  task automatic tally_and_finish;
    $display("mismatches %0d checks %0d", err_total, samples_checked);
    if (err_total == 0 && samples_checked > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  task automatic tick(inout int n);
    n++;
    if (n > 200) begin
      err_total++;
      $display("MISMATCH t=%0t bus wait too long", $time);
      tally_and_finish;
    end
  endtask

  // ==========================================
  // Bus cycles
  task automatic axw(input logic [7:0] a, input logic [31:0] v, input logic [1:0] er = RESP_OKAY);
    int   n;
    logic ad;
    logic dd;
    n = 0;
    ad = 1'b0;
    dd = 1'b0;
    @(posedge clk);
    awa <= a;
    wd <= v;
    awv <= 1'b1;
    wv <= 1'b1;
    bre <= 1'b1;
    while (!(ad && dd)) begin
      @(posedge clk);
      if (awv && awr === 1'b1) begin
        ad = 1'b1;
        awv <= 1'b0;
      end
      if (wv && wr === 1'b1) begin
        dd = 1'b1;
        wv <= 1'b0;
      end
      tick(n);
    end
    while (1) begin
      @(posedge clk);
      if (bv === 1'b1) break;
      tick(n);
    end
    chk_val({30'h0, br}, {30'h0, er});
    bre <= 1'b0;
  endtask

  task automatic axr(input logic [7:0] a, output logic [31:0] v, input logic [1:0] er = RESP_OKAY);
    int n;
    n = 0;
    @(posedge clk);
    ara <= a;
    arv <= 1'b1;
    rre <= 1'b1;
    while (1) begin
      @(posedge clk);
      if (rv === 1'b1) break;
      if (arr === 1'b1) arv <= 1'b0;
      tick(n);
    end
    v = rdat;
    chk_val({30'h0, rr}, {30'h0, er});
    rre <= 1'b0;
  endtask

  task automatic rchk(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] v;
    axr(a, v);
    chk_val(v, e);
  endtask

  // ==========================================
  // Main sequence
  initial begin
    rst_n = 1'b0;
    awv = 1'b0;
    wv = 1'b0;
    bre = 1'b0;
    arv = 1'b0;
    rre = 1'b0;
    awa = 8'h00;
    ara = 8'h00;
    wd = 32'h0;
    pin_rst = 2'b00;
    err_total = 0;
    samples_checked = 0;
    repeat (6) @(posedge clk);
    rst_n <= 1'b1;
    rchk(OFF_MODE, 32'h0);
    rchk(OFF_CMPA, 32'hff);
    axr(8'h80, d, RESP_SLVERR);
    chk_val(d, 32'h0);
    axw(8'h80, 32'h1, RESP_SLVERR);
    axw(OFF_CMPA, 32'h1);
    axw(CH_STRIDE + OFF_CMPA, 32'h5);
    axw(OFF_CSR, 32'h2);
    axw(CH_STRIDE + OFF_CSR, 32'h2);
    axw(OFF_CTRL, 32'({CLR_MA, CKS_CASC}));
    rchk(OFF_MODE, 32'h1);
    axw(CH_STRIDE + OFF_CTRL, 32'({CLR_MA, CKS_DIV1}));
    repeat (20) @(posedge clk);
    rchk(OFF_STAT, 32'h4);
    chk_bit(p1, 1'b1);
    chk_bit(p0, 1'b0);
    for (int k = 0; k < 2; k++) begin
      axw(OFF_CTRL, 32'({(k == 0) ? CLR_MA : CLR_PIN, CKS_CASC}));
      for (int r = 0; r < 2; r++) begin
        axw(OFF_STAT, 32'hf);
        repeat (300) @(posedge clk);
        axr(OFF_STAT, d);
        chk_val(d & 32'h1, 32'h1);
      end
    end
    chk_bit(p0, 1'b1);
    rst_n <= 1'b0;
    repeat (6) @(posedge clk);
    rst_n <= 1'b1;
    axw(OFF_CNT, 32'h2);
    axw(OFF_CMPA, 32'h3);
    axw(CH_STRIDE + OFF_CMPA, 32'h1);
    axw(CH_STRIDE + OFF_CSR, 32'h2);
    axw(CH_STRIDE + OFF_CTRL, 32'(CKS_CASC));
    rchk(OFF_MODE, 32'h2);
    axw(OFF_CTRL, 32'(CKS_DIV1));
    repeat (100) @(posedge clk);
    axw(OFF_CTRL, 32'(CKS_STOP));
    rchk(CH_STRIDE + OFF_CNT, 32'h1);
    rchk(OFF_STAT, 32'h5);
    chk_bit(p1, 1'b1);
    chk_bit(p0, 1'b0);
    chk_bit(irq, 1'b0);
    axw(OFF_MASK, 32'h4);
    chk_bit(irq, 1'b1);
    axw(OFF_STAT, 32'h4);
    rchk(OFF_STAT, 32'h1);
    chk_bit(irq, 1'b0);
    // own clear by match and by pin
    axw(CH_STRIDE + OFF_CNT, 32'h0);
    axw(CH_STRIDE + OFF_CTRL, 32'({CLR_MA, CKS_CASC}));
    axw(OFF_CNT, 32'h2);
    axw(OFF_CTRL, 32'({CLR_PIN, CKS_DIV1}));
    repeat (20) @(posedge clk);
    pin_rst <= 2'b01;
    @(posedge clk);
    pin_rst <= 2'b00;
    @(posedge clk);
    axw(OFF_CTRL, 32'(CKS_STOP));
    rchk(OFF_CNT, 32'h4);
    rchk(CH_STRIDE + OFF_CNT, 32'h0);
    rchk(OFF_STAT, 32'h5);
    chk_bit(irq, 1'b1);
    tally_and_finish;
  end
endmodule
